// file: design/fec_pkg.sv
package fec_pkg;
    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] FEC_REG_CTRL = 8'h00;
    localparam logic [7:0] FEC_REG_ADDR = 8'h04;
    localparam logic [7:0] FEC_REG_STATUS = 8'h08;
    localparam logic [7:0] FEC_REG_FLASH = 8'h0C;
    // ctrl register fields
    localparam int FEC_CTRL_GO = 0;
    localparam int FEC_CTRL_CMD_LSB = 4;
    localparam int FEC_CTRL_RESET = 8;
    // host command codes written to ctrl
    localparam logic [2:0] FEC_OP_ERASE = 3'h1;
    localparam logic [2:0] FEC_OP_POLL = 3'h2;
    localparam logic [2:0] FEC_OP_CLEAR = 3'h3;
    localparam logic [2:0] FEC_OP_READ_ARRAY = 3'h4;
    localparam logic [2:0] FEC_OP_READ = 3'h5;
    // device command codes
    localparam logic [7:0] FEC_CODE_ERASE_SETUP = 8'h20;
    localparam logic [7:0] FEC_CODE_ERASE_CONFIRM = 8'hD0;
    localparam logic [7:0] FEC_CODE_READ_ARRAY = 8'hFF;
    localparam logic [7:0] FEC_CODE_CLEAR_STATUS = 8'h50;
    // operation_status bit positions
    localparam int FEC_SR_READY = 7;
    localparam int FEC_SR_ERASE_ERR = 5;
    localparam int FEC_SR_PROG_ERR = 4;
    localparam int FEC_SR_SUPPLY_LOW = 3;
    // pin geometry
    localparam int FEC_AW = 18;
    localparam int FEC_DW = 16;
    // bus timing: clock period and strobe time
    localparam int FEC_CLK_NS = 25;
    localparam int FEC_STROBE_NS = 100;
    localparam int FEC_STROBE_CYC = (FEC_STROBE_NS + FEC_CLK_NS - 1) / FEC_CLK_NS;
    localparam logic [1:0] FEC_RESP_OKAY = 2'h0;
    localparam logic [1:0] FEC_RESP_SLVERR = 2'h2;
    typedef enum logic [6:0] {
        FEC_IDLE = 7'b0000001,
        FEC_SETUP = 7'b0000010,
        FEC_STROBE = 7'b0000100,
        FEC_GAP = 7'b0001000,
        FEC_POLL = 7'b0010000,
        FEC_DONE = 7'b0100000,
        FEC_RESET = 7'b1000000
    } fec_state_e;
endpackage

// file: design/fec_cycle.sv
`timescale 1ns/1ps
`default_nettype none
// strobe timer: holds a strobe for the fixed count of cycles
module fec_cycle (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic busy,
    output logic last
);
    import fec_pkg::*;
    logic [7:0] count; // cycles remaining
    // load on start, count down to zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 8'h00;
        end else if (start) begin
            count <= 8'(FEC_STROBE_CYC);
        end else if (count != 8'h00) begin
            count <= count - 8'h01;
        end
    end
    assign busy = (count != 8'h00);
    assign last = (count == 8'h01);
endmodule
`default_nettype wire

// file: design/fec_host.sv
// Our own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fec_host (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    output logic [fec_pkg::FEC_AW-1:0] flash_addr,
    input wire logic [fec_pkg::FEC_DW-1:0] flash_dq_in,
    output logic [fec_pkg::FEC_DW-1:0] flash_dq_out,
    output logic flash_dq_oe_n,
    output logic chip_enable_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic reset_powerdown_n
);
    import fec_pkg::*;

    fec_state_e state; // sequencer state
    logic [2:0] op; // current host command
    logic [1:0] phase; // write index within command
    logic is_write; // current strobe is a write
    logic [FEC_AW-1:0] block_addr; // target address
    logic [7:0] status; // last status byte seen
    logic [FEC_DW-1:0] read_data; // last array word
    logic hold_reset; // software holds device in reset
    logic [FEC_DW-1:0] dq_s1, dq_s2; // pin synchroniser
    logic aw_hold, w_hold; // write channels taken
    logic [7:0] aw_addr; // latched write address
    logic [31:0] w_data; // latched write data
    logic go; // start pulse from ctrl write
    logic t_start, t_busy, t_last;

    // decode the device code for a command and phase
    function automatic logic [7:0] dev_code(input logic [2:0] o, input logic [1:0] p);
        case (o)
            FEC_OP_ERASE: dev_code = (p == 2'h0) ? FEC_CODE_ERASE_SETUP
                                                 : FEC_CODE_ERASE_CONFIRM;
            FEC_OP_CLEAR: dev_code = FEC_CODE_CLEAR_STATUS;
            FEC_OP_READ_ARRAY: dev_code = FEC_CODE_READ_ARRAY;
            default: dev_code = 8'h00;
        endcase
    endfunction

    // number of writes each command needs
    function automatic logic [1:0] n_writes(input logic [2:0] o);
        case (o)
            FEC_OP_ERASE: n_writes = 2'h2;
            FEC_OP_CLEAR, FEC_OP_READ_ARRAY: n_writes = 2'h1;
            default: n_writes = 2'h0;
        endcase
    endfunction

    fec_cycle u_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(t_start),
        .busy(t_busy),
        .last(t_last)
    );

    // two-stage synchroniser on the data pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dq_s1 <= '0;
            dq_s2 <= '0;
        end else begin
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    // write address and data channels, taken in either order
    assign s_axil_awready = !aw_hold && !s_axil_bvalid;
    assign s_axil_wready = !w_hold && !s_axil_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= FEC_RESP_OKAY;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_hold <= 1'b1;
                w_data <= s_axil_wdata;
            end
            if (aw_hold && w_hold) begin
                // both halves present: respond
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp <= (aw_addr == FEC_REG_CTRL || aw_addr == FEC_REG_ADDR)
                                ? FEC_RESP_OKAY : FEC_RESP_SLVERR;
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // register writes: target address, command launch
    assign go = aw_hold && w_hold && aw_addr == FEC_REG_CTRL && w_data[FEC_CTRL_GO]
                && state == FEC_IDLE;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            block_addr <= '0;
            op <= 3'h0;
            hold_reset <= 1'b0;
        end else if (aw_hold && w_hold) begin
            if (aw_addr == FEC_REG_ADDR) begin
                block_addr <= w_data[FEC_AW-1:0];
            end else if (aw_addr == FEC_REG_CTRL) begin
                hold_reset <= w_data[FEC_CTRL_RESET];
                if (go) begin
                    op <= w_data[FEC_CTRL_CMD_LSB +: 3];
                end
            end
        end
    end

    // read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0;
            s_axil_rresp <= FEC_RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rresp <= FEC_RESP_OKAY;
            case (s_axil_araddr)
                FEC_REG_CTRL: s_axil_rdata <= {23'h0, hold_reset, 1'b0, op, 3'h0,
                                               state != FEC_IDLE};
                FEC_REG_ADDR: s_axil_rdata <= {14'h0, block_addr};
                FEC_REG_STATUS: s_axil_rdata <= {24'h0, status};
                FEC_REG_FLASH: s_axil_rdata <= {16'h0, read_data};
                default: begin
                    s_axil_rdata <= 32'h0;
                    s_axil_rresp <= FEC_RESP_SLVERR;
                end
            endcase
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end
    assign s_axil_arready = !s_axil_rvalid;

    // sequencer: writes, read cycles and status polling
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= FEC_IDLE;
            phase <= 2'h0;
            is_write <= 1'b0;
            status <= 8'h00;
            read_data <= '0;
        end else if (hold_reset && state != FEC_RESET) begin // software hold aborts work
            state <= FEC_RESET;
            status <= 8'h00;
        end else begin
            case (state)
                FEC_IDLE: begin
                    phase <= 2'h0;
                    if (go) begin
                        state <= FEC_SETUP;
                    end
                end
                FEC_SETUP: begin
                    // writes first, then one read cycle per pass if needed
                    is_write <= (phase < n_writes(op));
                    if (phase >= n_writes(op) && op != FEC_OP_ERASE && op != FEC_OP_POLL
                        && op != FEC_OP_READ) begin
                        state <= FEC_DONE;
                    end else begin
                        state <= FEC_STROBE;
                    end
                end
                FEC_STROBE: begin
                    if (t_last) begin
                        if (!is_write) begin
                            // sample synchronised pins as the strobe ends
                            if (op == FEC_OP_READ) begin
                                read_data <= dq_s2;
                            end else begin
                                status <= dq_s2[7:0];
                            end
                        end
                        state <= FEC_GAP;
                    end
                end
                FEC_GAP: begin
                    if (!t_busy) begin
                        if (is_write) begin
                            phase <= phase + 2'h1;
                            state <= FEC_SETUP;
                        end else if (op == FEC_OP_READ) begin
                            state <= FEC_DONE;
                        end else begin
                            state <= FEC_POLL;
                        end
                    end
                end
                FEC_POLL: begin
                    // ready bit ends the wait; errors stay for software
                    if (status[FEC_SR_READY]) begin
                        state <= FEC_DONE;
                    end else begin
                        state <= FEC_SETUP;
                    end
                end
                FEC_DONE: begin
                    state <= FEC_IDLE;
                end
                FEC_RESET: begin
                    if (!hold_reset) begin
                        state <= FEC_IDLE;
                    end
                end
                default: state <= FEC_IDLE;
            endcase
        end
    end

    assign t_start = (state == FEC_SETUP) && !(phase >= n_writes(op) && op != FEC_OP_ERASE
                     && op != FEC_OP_POLL && op != FEC_OP_READ);

    // pin drivers, all from flip-flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            chip_enable_n <= 1'b1;
            output_enable_n <= 1'b1;
            write_enable_n <= 1'b1;
            flash_dq_oe_n <= 1'b1;
            flash_dq_out <= '0;
            flash_addr <= '0;
            reset_powerdown_n <= 1'b0;
        end else begin
            reset_powerdown_n <= !hold_reset;
            flash_addr <= block_addr;
            if (state == FEC_STROBE && !hold_reset) begin // low for all strobe cycles
                // new cycle each poll refreshes status
                chip_enable_n <= 1'b0;
                write_enable_n <= !is_write;
                output_enable_n <= is_write;
                flash_dq_oe_n <= !is_write;
                flash_dq_out <= {8'h00, dev_code(op, phase)};
            end else begin
                // release all three strobes to block stray writes
                chip_enable_n <= 1'b1;
                write_enable_n <= 1'b1;
                output_enable_n <= 1'b1;
                flash_dq_oe_n <= !(is_write && state == FEC_GAP); // data held past strobe
            end
        end
    end
endmodule
`default_nettype wire

// file: test/fec_host_sva.sv
`timescale 1ns/1ps
`default_nettype none
// pin and bus-answer checks on the flash host, clocked on aclk
module fec_host_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [fec_pkg::FEC_AW-1:0] flash_addr,
    input wire logic flash_dq_oe_n,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic reset_powerdown_n
);
    import fec_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    chk_write_select: assert property (!write_enable_n |-> !chip_enable_n)
        else $error("write strobe without chip select");
    chk_write_no_read: assert property (!write_enable_n |-> output_enable_n)
        else $error("write and read strobes low together");
    chk_write_drives: assert property (!write_enable_n |-> !flash_dq_oe_n)
        else $error("data not driven during write strobe");
    chk_read_floats: assert property (!output_enable_n |-> flash_dq_oe_n)
        else $error("host drives data during read strobe");
    chk_pd_quiet: assert property (!reset_powerdown_n |-> chip_enable_n && write_enable_n)
        else $error("strobes active while device held down");
    chk_write_width: assert property ($fell(write_enable_n) |-> !write_enable_n [*4])
        else $error("write strobe too short");
    chk_read_width: assert property ($fell(output_enable_n) |-> !output_enable_n [*4])
        else $error("read strobe too short");
    chk_addr_hold: assert property (!write_enable_n && $past(!write_enable_n) |->
        $stable(flash_addr))
        else $error("address moved inside write strobe");
    chk_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid)
        else $error("write answer not withdrawn");
endmodule
bind fec_host fec_host_chk chk (.aclk, .aresetn, .s_axil_arvalid, .s_axil_arready,
    .s_axil_rvalid, .s_axil_bvalid, .s_axil_bready, .flash_addr, .flash_dq_oe_n,
    .chip_enable_n, .output_enable_n, .write_enable_n, .reset_powerdown_n);
`default_nettype wire

// file: test/fec_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural flash device: command decode, status flags, timed erase
module fec_flash_model #(parameter int ERASE_NS = 3000) (
    input wire logic [fec_pkg::FEC_AW-1:0] flash_addr,
    input wire logic [fec_pkg::FEC_DW-1:0] dq_bus,
    input wire logic chip_enable_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic reset_powerdown_n,
    input wire logic supply_low,
    output logic [fec_pkg::FEC_DW-1:0] dev_dq
);
    import fec_pkg::*;
    logic [7:0] status = 8'h00; // error flags, ready added at read
    logic st_mode = 1'b0; // power-up in array read
    logic setup = 1'b0; // erase setup seen
    logic [7:0] erased = 8'h00; // one flag per block
    realtime done_at = 0.0; // end of running erase
    wire [2:0] blk = flash_addr[17:15];
    initial dev_dq = 16'h0000;
    // write cycle: both strobes low while the device is out of reset
    wire wr_on = !write_enable_n && !chip_enable_n && reset_powerdown_n;
    // commands land as the write cycle ends, whichever strobe rises first
    always @(negedge wr_on or negedge reset_powerdown_n) begin
        if (!reset_powerdown_n) begin
            status = 8'h00;
            st_mode = 1'b0;
            setup = 1'b0;
            if ($realtime < done_at) erased[blk] = 1'b0;
            done_at = 0.0;
        end else begin
            if (setup) begin
                if (dq_bus[7:0] != FEC_CODE_ERASE_CONFIRM) status |= 8'h30;
                else if (supply_low || status[FEC_SR_SUPPLY_LOW]) status |= 8'h28;
                else begin
                    erased[blk] = 1'b1;
                    done_at = $realtime + ERASE_NS;
                end
                setup = 1'b0;
            end else begin
                setup = (dq_bus[7:0] == FEC_CODE_ERASE_SETUP);
                st_mode = (dq_bus[7:0] != FEC_CODE_READ_ARRAY);
                if (dq_bus[7:0] == FEC_CODE_CLEAR_STATUS) status[5:3] = 3'b000;
            end
        end
    end
    // each read cycle refreshes; released pins show the inverted old value
    always @(chip_enable_n, output_enable_n, reset_powerdown_n, flash_addr) begin
        if (chip_enable_n || output_enable_n || !reset_powerdown_n) dev_dq = ~dev_dq;
        else if (st_mode) dev_dq = {8'h00, status | (($realtime >= done_at) ? 8'h80 : 8'h00)};
        else dev_dq = erased[blk] ? 16'hFFFF : flash_addr[15:0] ^ 16'h5A5A;
    end
endmodule
`default_nettype wire

// file: test/tb_fec_host.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fec_host;
    import fec_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
    logic [3:0] s_axil_wstrb = 4'hF; // lanes ignored by the host
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0, supply_low = 1'b0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [FEC_AW-1:0] flash_addr;
    logic [FEC_DW-1:0] flash_dq_out, dev_dq, dq_bus;
    logic flash_dq_oe_n, chip_enable_n, output_enable_n, write_enable_n, reset_powerdown_n;
    int fail_count = 0;
    int checked = 0;
    // wire level: host drives while its enable is low
    assign dq_bus = flash_dq_oe_n ? dev_dq : flash_dq_out;
    always #12.5 aclk = ~aclk;
    fec_host DUT (.aclk, .aresetn, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp,
        .s_axil_bvalid, .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
        .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready, .flash_addr,
        .flash_dq_in(dq_bus), .flash_dq_out, .flash_dq_oe_n, .chip_enable_n,
        .output_enable_n, .write_enable_n, .reset_powerdown_n);
    fec_flash_model mdl (.flash_addr, .dq_bus, .chip_enable_n, .output_enable_n,
        .write_enable_n, .reset_powerdown_n, .supply_low, .dev_dq);
    task automatic print_verdict();
        $display("counts: checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write: both halves offered, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
        end while (!s_axil_bvalid);
        r = s_axil_bresp;
        s_axil_bready <= 1'b0;
        @(posedge aclk); // an edge with bready low before the next request
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
        end while (!s_axil_rvalid);
        s_axil_rready <= 1'b0;
        cmp(s_axil_rdata, e);
        cmp({30'h0, s_axil_rresp}, {30'h0, er});
        @(posedge aclk); // an edge with rready low before the next request
    endtask
    // start an operation and wait for the pins to fall quiet
    task automatic run(input logic [2:0] c);
        logic [1:0] r;
        int n;
        axw(FEC_REG_CTRL, (32'(c) << FEC_CTRL_CMD_LSB) | 32'h1, r);
        n = 0;
        while (n < 16) begin
            @(posedge aclk);
            n = chip_enable_n ? n + 1 : 0;
        end
    endtask
    task automatic t_bus();
        logic [1:0] r;
        axw(8'h10, 32'h0, r);
        cmp({30'h0, r}, {30'h0, FEC_RESP_SLVERR});
        chk_reg(8'h10, 32'h0, FEC_RESP_SLVERR);
        axw(FEC_REG_ADDR, 32'h1_2345, r);
        repeat (2) @(posedge aclk);
        cmp({14'h0, flash_addr}, 32'h1_2345);
        $display("bus test done");
    endtask
    task automatic t_erase();
        logic [1:0] r;
        axw(FEC_REG_ADDR, 32'h1_0010, r);
        run(FEC_OP_ERASE);
        chk_reg(FEC_REG_STATUS, 32'h80, FEC_RESP_OKAY);
        cmp({31'h0, mdl.erased[2]}, 32'h1);
        run(FEC_OP_READ_ARRAY);
        run(FEC_OP_READ);
        chk_reg(FEC_REG_FLASH, 32'hFFFF, FEC_RESP_OKAY);
        $display("erase test done");
    endtask
    task automatic t_errs();
        logic [1:0] r;
        supply_low <= 1'b1;
        axw(FEC_REG_ADDR, 32'h1_8000, r);
        run(FEC_OP_ERASE);
        chk_reg(FEC_REG_STATUS, 32'hA8, FEC_RESP_OKAY);
        supply_low <= 1'b0;
        run(FEC_OP_ERASE);
        chk_reg(FEC_REG_STATUS, 32'hA8, FEC_RESP_OKAY);
        cmp({31'h0, mdl.erased[3]}, 32'h0);
        run(FEC_OP_CLEAR);
        run(FEC_OP_POLL);
        chk_reg(FEC_REG_STATUS, 32'h80, FEC_RESP_OKAY);
        run(FEC_OP_ERASE);
        cmp({31'h0, mdl.erased[3]}, 32'h1);
        $display("error test done");
    endtask
    task automatic t_pd();
        logic [1:0] r;
        axw(FEC_REG_CTRL, 32'h100, r);
        repeat (4) @(posedge aclk);
        cmp({30'h0, reset_powerdown_n, chip_enable_n}, 32'h1);
        cmp({24'h0, mdl.status}, 32'h0);
        chk_reg(FEC_REG_STATUS, 32'h0, FEC_RESP_OKAY);
        axw(FEC_REG_ADDR, 32'h0_0042, r);
        axw(FEC_REG_CTRL, 32'h0, r);
        run(FEC_OP_READ);
        chk_reg(FEC_REG_FLASH, 32'h5A18, FEC_RESP_OKAY);
        $display("power-down test done");
    endtask
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_bus();
        t_erase();
        t_errs();
        t_pd();
        print_verdict();
    end
endmodule
`default_nettype wire
